// *** rtl/imurc_map.vh ***
`ifndef IMURC_MAP_VH
`define IMURC_MAP_VH
`define IMURC_ADDR_UP_LO     7'h62
`define IMURC_ADDR_UP_HI     7'h63
`define IMURC_ADDR_DEC_LO    7'h64
`define IMURC_ADDR_DEC_HI    7'h65
`define IMURC_ADDR_CMD_LO    7'h68
`define IMURC_ADDR_CMD_HI    7'h69
`define IMURC_ADDR_FW_LO     7'h6c
`define IMURC_ADDR_FW_HI     7'h6d
`define IMURC_ADDR_DM_LO     7'h6e
`define IMURC_ADDR_DM_HI     7'h6f
`define IMURC_ADDR_YR_LO     7'h70
`define IMURC_ADDR_YR_HI     7'h71
`define IMURC_UP_RESET       16'h07d0
`define IMURC_DEC_RESET      16'h0000
`define IMURC_DEC_MAX        11'h7cf
`define IMURC_DEC_BITS       11
`define IMURC_CMD_RESET_BIT  7
`define IMURC_CMD_FTEST_BIT  4
`define IMURC_CMD_FSAVE_BIT  3
`define IMURC_CMD_STEST_BIT  2
`define IMURC_CMD_RESTR_BIT  1
`define IMURC_DIAG_FTEST_BIT 6
`define IMURC_DIAG_STEST_BIT 5
`define IMURC_DIAG_FSAVE_BIT 2
`define IMURC_MODE_INT       2'h0
`define IMURC_MODE_DIRECT    2'h1
`define IMURC_MODE_SCALED    2'h2
`define IMURC_MODE_OUT       2'h3
`define IMURC_CLK_HZ         40000000
`define IMURC_INT_RATE_HZ    2000
`define IMURC_INT_DIV        (`IMURC_CLK_HZ / `IMURC_INT_RATE_HZ)
`define IMURC_DEC_LAT_NS     30000
`define IMURC_DEC_LAT_CYC    ((`IMURC_DEC_LAT_NS * 40) / 1000)
`define IMURC_PHASE_CYC      16
`define IMURC_SCALE_MIN_HZ   1
`define IMURC_SCALE_MAX_HZ   128
`endif

// *** rtl/imurc_sync_mult.v ***
`timescale 1ns/1ps
// scaled sync: measures sync period in core clocks, emits factor ticks per period
module imurc_sync_mult #(
  parameter CW = 26
) (
  input  wire          core_clk,
  input  wire          rst,
  input  wire          sync_edge,
  input  wire [15:0]   factor,
  output reg           tick
);
  reg [CW-1:0] period_cnt_reg;
  reg [CW-1:0] step_reg;
  reg [CW-1:0] phase_reg;
  reg [15:0]   left_reg;
  wire [15:0]  fac16 = (factor == 16'h0000) ? 16'h0001 : factor;
  wire [CW-1:0] fac_w = {{(CW-16){1'b0}}, fac16};

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      period_cnt_reg <= {CW{1'b0}};
      step_reg       <= {CW{1'b0}};
      phase_reg      <= {CW{1'b0}};
      left_reg       <= 16'h0000;
      tick           <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (sync_edge) begin
        // division once per sync edge; sync is at most 128 Hz
        // counter holds period minus one; the edge itself is one of the ticks
        step_reg       <= (period_cnt_reg + {{(CW-1){1'b0}}, 1'b1}) / fac_w;
        period_cnt_reg <= {CW{1'b0}};
        phase_reg      <= {CW{1'b0}};
        left_reg       <= fac16 - 16'h0001;
        tick           <= 1'b1;
      end else begin
        if (period_cnt_reg != {CW{1'b1}})
          period_cnt_reg <= period_cnt_reg + 1'b1;
        // never more than factor ticks per sync period, even when it shrinks
        if (step_reg != {CW{1'b0}} && left_reg != 16'h0000) begin
          if (phase_reg + 1'b1 >= step_reg) begin
            phase_reg <= {CW{1'b0}};
            left_reg  <= left_reg - 16'h0001;
            tick      <= 1'b1;
          end else begin
            phase_reg <= phase_reg + 1'b1;
          end
        end
      end
    end
  end
endmodule // imurc_sync_mult

// *** rtl/imurc_cmd_seq.v ***
`timescale 1ns/1ps
`include "imurc_map.vh"
// runs one global command at a time; busy holds off data and the port
module imurc_cmd_seq #(
  parameter RST_CYC   = 400,
  parameter FTEST_CYC = 800,
  parameter FSAVE_CYC = 800,
  parameter STEST_CYC = 600,
  parameter RESTR_CYC = 400
) (
  input  wire        core_clk,
  input  wire        rst,
  input  wire [4:0]  start,
  input  wire        flash_crc_bad,
  input  wire        flash_save_fail,
  input  wire        stest_fail,
  output reg         busy,
  output reg  [4:0]  op_reg,
  output reg         done,
  output reg         stim_on,
  output reg         ftest_flag,
  output reg         fsave_flag,
  output reg         stest_flag
);
  localparam S_IDLE = 4'b0001;
  localparam S_RUN  = 4'b0010;
  localparam S_STIM = 4'b0100;
  localparam S_DONE = 4'b1000;
  reg [3:0]  state_reg;
  reg [15:0] cnt_reg;
  function [15:0] op_len;
    input [4:0] op;
    begin
      case (op)
        5'h10:   op_len = RST_CYC[15:0];
        5'h08:   op_len = FTEST_CYC[15:0];
        5'h04:   op_len = FSAVE_CYC[15:0];
        5'h02:   op_len = STEST_CYC[15:0];
        default: op_len = RESTR_CYC[15:0];
      endcase
    end
  endfunction
  // start[4]=reset, [3]=flash test, [2]=flash save, [1]=self test, [0]=restore
  wire [4:0] pick = start[4] ? 5'h10 : start[3] ? 5'h08 : start[2] ? 5'h04 :
                    start[1] ? 5'h02 : start[0] ? 5'h01 : 5'h00;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg  <= S_IDLE;
      cnt_reg    <= 16'h0000;
      op_reg     <= 5'h00;
      busy       <= 1'b0;
      done       <= 1'b0;
      stim_on    <= 1'b0;
      ftest_flag <= 1'b0;
      fsave_flag <= 1'b0;
      stest_flag <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (pick != 5'h00) begin
            op_reg    <= pick;
            cnt_reg   <= op_len(pick);
            busy      <= 1'b1;
            state_reg <= S_RUN;
          end
        end
        S_RUN: begin
          if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
          end else if (op_reg == 5'h02 && !stim_on) begin
            stim_on   <= 1'b1;
            cnt_reg   <= op_len(op_reg);
            state_reg <= S_STIM;
          end else begin
            state_reg <= S_DONE;
          end
        end
        S_STIM: begin
          if (cnt_reg != 16'h0000) begin
            cnt_reg <= cnt_reg - 16'h0001;
          end else begin
            stim_on   <= 1'b0;
            state_reg <= S_DONE;
          end
        end
        S_DONE: begin
          if (op_reg == 5'h08 && flash_crc_bad)
            ftest_flag <= 1'b1;
          if (op_reg == 5'h04)
            fsave_flag <= flash_save_fail;
          if (op_reg == 5'h02)
            stest_flag <= stest_fail;
          if (op_reg == 5'h10) begin
            ftest_flag <= 1'b0;
            fsave_flag <= 1'b0;
            stest_flag <= 1'b0;
          end
          busy      <= 1'b0;
          done      <= 1'b1;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end
endmodule // imurc_cmd_seq

// *** rtl/imurc_regs.v ***
`timescale 1ns/1ps
`include "imurc_map.vh"
module imurc_regs #(
  parameter FW_VERSION   = 16'h0100,
  parameter CFG_MONTHDAY = 16'h0101,
  parameter CFG_YEAR     = 16'h2000,
  parameter DEC_LAT_CYC  = `IMURC_DEC_LAT_CYC,
  parameter INT_DIV      = `IMURC_INT_DIV,
  parameter SW           = 16
) (
  input  wire          core_clk,
  input  wire          rst,
  input  wire          wr_stb,
  input  wire          rd_stb,
  input  wire [6:0]    addr,
  input  wire [7:0]    wdata,
  output reg  [15:0]   rdata,
  output reg           rvalid,
  input  wire [15:0]   misc_control_in,
  input  wire [15:0]   filter_control_in,
  output reg  [15:0]   misc_control_restore,
  output reg  [15:0]   filter_control_restore,
  output reg           control_restore_stb,
  output reg  [191:0]  bias_correction_words,
  input  wire          sync_pin,
  output reg           sync_out,
  output reg           sync_oe_n,
  input  wire [SW-1:0] gyro_sample,
  input  wire [SW-1:0] accel_sample,
  output reg  [SW-1:0] gyro_avg,
  output reg  [SW-1:0] accel_avg,
  output reg  [31:0]   delta_angle,
  output reg  [31:0]   delta_velocity,
  output reg           sample_ready_strobe,
  input  wire          flash_crc_bad,
  input  wire          flash_save_fail,
  input  wire          stest_fail,
  output wire          stimulus_on,
  output wire          cmd_busy,
  output wire [7:0]    diagnostic_flags
);
  reg [15:0] sync_rate_multiplier_reg;
  reg [15:0] up_active_reg;
  reg [1:0]  mode_active_reg;
  reg [10:0] dec_shadow_reg;
  reg [10:0] decimation_count_reg;
  reg [15:0] dec_lat_reg;
  reg        sync_s1_reg;
  reg        sync_s2_reg;
  reg        sync_prev_reg;
  reg [15:0] int_cnt_reg;
  reg        int_tick_reg;
  reg [10:0] samp_cnt_reg;
  reg [SW+10:0] gyro_acc_reg;
  reg [SW+10:0] accel_acc_reg;
  reg [31:0] dang_acc_reg;
  reg [31:0] dvel_acc_reg;
  reg        restart_reg;
  reg [4:0]  cmd_start;
  wire       seq_done;
  wire [4:0] seq_op;
  wire       ftest_flag;
  wire       fsave_flag;
  wire       stest_flag;
  wire       scaled_tick;
  wire       sync_edge = sync_s2_reg & ~sync_prev_reg;
  wire [1:0] mode_cfg = misc_control_in[3:2];

  imurc_cmd_seq u_seq (
    .core_clk        (core_clk),
    .rst             (rst),
    .start           (cmd_start),
    .flash_crc_bad   (flash_crc_bad),
    .flash_save_fail (flash_save_fail),
    .stest_fail      (stest_fail),
    .busy            (cmd_busy),
    .op_reg          (seq_op),
    .done            (seq_done),
    .stim_on         (stimulus_on),
    .ftest_flag      (ftest_flag),
    .fsave_flag      (fsave_flag),
    .stest_flag      (stest_flag)
  );

  imurc_sync_mult u_mult (
    .core_clk  (core_clk),
    .rst       (rst),
    .sync_edge (sync_edge & ~cmd_busy),
    .factor    (up_active_reg),
    .tick      (scaled_tick)
  );

  assign diagnostic_flags = {1'b0, ftest_flag, stest_flag, 2'b00, fsave_flag, 2'b00};

  function is_addr;
    input [6:0] a;
    input [6:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  function [SW+10:0] sext_acc;
    input [SW-1:0] s;
    begin
      sext_acc = {{11{s[SW-1]}}, s};
    end
  endfunction

  function [31:0] sext_delta;
    input [SW-1:0] s;
    begin
      sext_delta = {{(32-SW){s[SW-1]}}, s};
    end
  endfunction

  wire soft_reset_done = seq_done & (seq_op == 5'h10);
  wire restore_done    = seq_done & (seq_op == 5'h01);
  wire wr_ok = wr_stb & ~cmd_busy;
  wire rd_ok = rd_stb & ~cmd_busy;

  always @* begin
    cmd_start = 5'h00;
    if (wr_ok && is_addr(addr, `IMURC_ADDR_CMD_LO)) begin
      cmd_start = {wdata[`IMURC_CMD_RESET_BIT], wdata[`IMURC_CMD_FTEST_BIT],
                   wdata[`IMURC_CMD_FSAVE_BIT], wdata[`IMURC_CMD_STEST_BIT],
                   wdata[`IMURC_CMD_RESTR_BIT]};
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_rate_multiplier_reg <= `IMURC_UP_RESET;
      dec_shadow_reg           <= 11'h000;
      decimation_count_reg     <= 11'h000;
      dec_lat_reg              <= 16'h0000;
      bias_correction_words    <= 192'h0;
      misc_control_restore     <= 16'h0000;
      filter_control_restore   <= 16'h0000;
      control_restore_stb      <= 1'b0;
    end else begin
      control_restore_stb <= 1'b0;
      if (wr_ok) begin
        // stored at once; multiplier applied at restart, decimation after DEC_LAT_CYC cycles
        if (is_addr(addr, `IMURC_ADDR_UP_LO))
          sync_rate_multiplier_reg[7:0] <= wdata;
        if (is_addr(addr, `IMURC_ADDR_UP_HI))
          sync_rate_multiplier_reg[15:8] <= wdata;
        if (is_addr(addr, `IMURC_ADDR_DEC_LO)) begin
          dec_shadow_reg[7:0] <= wdata;
          dec_lat_reg         <= DEC_LAT_CYC[15:0];
        end
        if (is_addr(addr, `IMURC_ADDR_DEC_HI)) begin
          dec_shadow_reg[10:8] <= wdata[2:0];
          dec_lat_reg          <= DEC_LAT_CYC[15:0];
        end
      end
      if (dec_lat_reg != 16'h0000) begin
        dec_lat_reg <= dec_lat_reg - 16'h0001;
        if (dec_lat_reg == 16'h0001)
          decimation_count_reg <= (dec_shadow_reg > `IMURC_DEC_MAX) ?
                                  `IMURC_DEC_MAX : dec_shadow_reg;
      end
      if (restore_done) begin
        dec_shadow_reg         <= 11'h000;
        decimation_count_reg   <= 11'h000;
        bias_correction_words  <= 192'h0;
        misc_control_restore   <= 16'h0000;
        filter_control_restore <= 16'h0000;
        control_restore_stb    <= 1'b1;
      end
      if (soft_reset_done) begin
        sync_rate_multiplier_reg <= `IMURC_UP_RESET;
        dec_shadow_reg           <= 11'h000;
        decimation_count_reg     <= 11'h000;
        dec_lat_reg              <= 16'h0000;
      end
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata  <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= rd_ok;
      if (rd_ok) begin
        case ({addr[6:1], 1'b0})
          `IMURC_ADDR_UP_LO:  rdata <= up_active_reg;
          `IMURC_ADDR_DEC_LO: rdata <= {5'h00, decimation_count_reg};
          `IMURC_ADDR_FW_LO:  rdata <= FW_VERSION;
          `IMURC_ADDR_DM_LO:  rdata <= CFG_MONTHDAY;
          `IMURC_ADDR_YR_LO:  rdata <= {2'b00, CFG_YEAR[13:0]};
          default:            rdata <= 16'h0000;
        endcase
      end
    end
  end

  // readback shows active copy only after restart
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      up_active_reg   <= `IMURC_UP_RESET;
      mode_active_reg <= `IMURC_MODE_INT;
      restart_reg     <= 1'b0;
    end else begin
      restart_reg <= (sync_rate_multiplier_reg != up_active_reg) ||
                     (mode_cfg != mode_active_reg);
      if (restart_reg && samp_cnt_reg == 11'h000) begin
        up_active_reg   <= sync_rate_multiplier_reg;
        mode_active_reg <= mode_cfg;
      end
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync_s1_reg   <= 1'b0;
      sync_s2_reg   <= 1'b0;
      sync_prev_reg <= 1'b0;
      int_cnt_reg   <= 16'h0000;
      int_tick_reg  <= 1'b0;
      sync_out      <= 1'b0;
      sync_oe_n     <= 1'b1;
    end else begin
      sync_s1_reg   <= sync_pin;
      sync_s2_reg   <= sync_s1_reg;
      sync_prev_reg <= sync_s2_reg;
      int_tick_reg  <= 1'b0;
      if (int_cnt_reg == INT_DIV[15:0] - 16'h0001 || cmd_busy) begin
        int_cnt_reg  <= 16'h0000;
        int_tick_reg <= ~cmd_busy;
      end else begin
        int_cnt_reg <= int_cnt_reg + 16'h0001;
      end
      sync_oe_n <= (mode_active_reg != `IMURC_MODE_OUT);
      sync_out  <= (int_cnt_reg < INT_DIV[15:0] / 16'h0002);
    end
  end

  reg samp_tick;
  always @* begin
    case (mode_active_reg)
      `IMURC_MODE_DIRECT: samp_tick = sync_edge;
      `IMURC_MODE_SCALED: samp_tick = scaled_tick;
      default:            samp_tick = int_tick_reg;
    endcase
  end

  // signed sums; an unsigned divide corrupts negative averages
  wire signed [SW+10:0] gyro_sum  = gyro_acc_reg + sext_acc(gyro_sample);
  wire signed [SW+10:0] accel_sum = accel_acc_reg + sext_acc(accel_sample);
  wire signed [SW+10:0] avg_div   = {{SW{1'b0}}, decimation_count_reg + 11'h001};
  wire signed [SW+10:0] gyro_quo  = gyro_sum / avg_div;
  wire signed [SW+10:0] accel_quo = accel_sum / avg_div;
  wire [31:0]           dang_sum  = dang_acc_reg + sext_delta(gyro_sample);
  wire [31:0]           dvel_sum  = dvel_acc_reg + sext_delta(accel_sample);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      samp_cnt_reg        <= 11'h000;
      gyro_acc_reg        <= {(SW+11){1'b0}};
      accel_acc_reg       <= {(SW+11){1'b0}};
      dang_acc_reg        <= 32'h0;
      dvel_acc_reg        <= 32'h0;
      gyro_avg            <= {SW{1'b0}};
      accel_avg           <= {SW{1'b0}};
      delta_angle         <= 32'h0;
      delta_velocity      <= 32'h0;
      sample_ready_strobe <= 1'b0;
    end else begin
      sample_ready_strobe <= 1'b0;
      if (cmd_busy || restart_reg) begin
        samp_cnt_reg  <= 11'h000;
        gyro_acc_reg  <= {(SW+11){1'b0}};
        accel_acc_reg <= {(SW+11){1'b0}};
        dang_acc_reg  <= 32'h0;
        dvel_acc_reg  <= 32'h0;
        if (soft_reset_done || seq_op == 5'h10) begin
          gyro_avg       <= {SW{1'b0}};
          accel_avg      <= {SW{1'b0}};
          delta_angle    <= 32'h0;
          delta_velocity <= 32'h0;
        end
      end else if (samp_tick) begin
        if (samp_cnt_reg >= decimation_count_reg) begin
          samp_cnt_reg        <= 11'h000;
          gyro_avg            <= gyro_quo[SW-1:0];
          accel_avg           <= accel_quo[SW-1:0];
          delta_angle         <= dang_sum;
          delta_velocity      <= dvel_sum;
          gyro_acc_reg        <= {(SW+11){1'b0}};
          accel_acc_reg       <= {(SW+11){1'b0}};
          dang_acc_reg        <= 32'h0;
          dvel_acc_reg        <= 32'h0;
          sample_ready_strobe <= 1'b1;
        end else begin
          samp_cnt_reg  <= samp_cnt_reg + 11'h001;
          gyro_acc_reg  <= gyro_sum;
          accel_acc_reg <= accel_sum;
          dang_acc_reg  <= dang_sum;
          dvel_acc_reg  <= dvel_sum;
        end
      end
    end
  end
endmodule // imurc_regs

// *** testbench/imurc_chk.sv ***
`timescale 1ns/1ps
module imurc_chk (
  input logic        core_clk,
  input logic        rst,
  input logic        wr_stb,
  input logic        rd_stb,
  input logic [6:0]  addr,
  input logic [7:0]  wdata,
  input logic [15:0] rdata,
  input logic        rvalid,
  input logic [15:0] misc_control_restore,
  input logic [15:0] filter_control_restore,
  input logic        control_restore_stb,
  input logic        sample_ready_strobe,
  input logic        stimulus_on,
  input logic        cmd_busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  function automatic logic bcd(input logic [15:0] v);
    return v[3:0] < 10 && v[7:4] < 10 && v[11:8] < 10 && v[15:12] < 10;
  endfunction
  logic rd_ok;
  logic cmd_wr;
  assign rd_ok = rd_stb && !cmd_busy;
  assign cmd_wr = wr_stb && !cmd_busy && addr == 7'h68;
  property p_rd_ans; rd_ok |=> rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rv_cause; rvalid |-> $past(rd_stb) && !$past(cmd_busy); endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("answer without idle read");
  property p_no_dr; cmd_busy && $past(cmd_busy) |-> !sample_ready_strobe; endproperty
  a_no_dr: assert property (p_no_dr) else $error("ready pulse during command");
  property p_cmd_go; cmd_wr && (wdata & 8'h9e) != 0 |=> cmd_busy; endproperty
  a_cmd_go: assert property (p_cmd_go) else $error("command not started");
  property p_cmd_nop;
    wr_stb && !cmd_busy && (addr == 7'h69 || (addr == 7'h68 && (wdata & 8'h9e) == 0))
      |=> !cmd_busy;
  endproperty
  a_cmd_nop: assert property (p_cmd_nop) else $error("unused bit started command");
  property p_bcd; rd_ok && addr[6:1] inside {6'h36, 6'h37, 6'h38} |=> bcd(rdata); endproperty
  a_bcd: assert property (p_bcd) else $error("factory word not bcd");
  property p_yr; rd_ok && addr[6:1] == 6'h38 |=> rdata[15:14] == 2'b00; endproperty
  a_yr: assert property (p_yr) else $error("year word upper bits set");
  property p_rest;
    control_restore_stb |-> misc_control_restore == 16'h0000 && filter_control_restore == 16'h0000;
  endproperty
  a_rest: assert property (p_rest) else $error("restore value wrong");
  property p_gap; sample_ready_strobe |=> !sample_ready_strobe [*8]; endproperty
  a_gap: assert property (p_gap) else $error("ready pulses too close");
  property p_stim; stimulus_on |-> cmd_busy; endproperty
  a_stim: assert property (p_stim) else $error("stimulus outside command");
  c_cmd: cover property ($rose(cmd_busy));
  c_stim: cover property (stimulus_on);
  c_dr: cover property (sample_ready_strobe ##[1:400] sample_ready_strobe);
endmodule // imurc_chk
bind imurc_regs imurc_chk chk_u (.core_clk, .rst, .wr_stb, .rd_stb, .addr, .wdata, .rdata,
  .rvalid, .misc_control_restore, .filter_control_restore, .control_restore_stb,
  .sample_ready_strobe, .stimulus_on, .cmd_busy);

// *** testbench/imurc_host.sv ***
`timescale 1ns/1ps
module imurc_host (
  input  logic        core_clk,
  output logic        wr_stb,
  output logic        rd_stb,
  output logic [6:0]  addr,
  output logic [7:0]  wdata,
  input  logic [15:0] rdata,
  input  logic        rvalid,
  input  logic        sample_ready_strobe
);
  initial begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 7'h7f;
    wdata = 8'h00;
  end
  task automatic wr_byte(input logic [6:0] a, input logic [7:0] d);
    @(posedge core_clk);
    wr_stb <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    // released bus must not keep a plausible value
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic wr16(input logic [6:0] a, input logic [15:0] v);
    wr_byte(a, v[7:0]);
    wr_byte(a | 7'h01, v[15:8]);
  endtask
  task automatic rd16(input logic [6:0] a, output logic [15:0] v, output logic ok);
    @(posedge core_clk);
    rd_stb <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd_stb <= 1'b0;
    addr <= ~a;
    #1;
    ok = rvalid;
    v = rdata;
  endtask
  // readback trusted after a ready pulse
  task automatic wait_dr(input int n, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < n && !ok; i++) begin
      @(posedge core_clk);
      #1;
      ok = (sample_ready_strobe === 1'b1);
    end
  endtask
endmodule // imurc_host

// *** testbench/imurc_regs_tb.sv ***
`timescale 1ns/1ps
module imurc_regs_tb;
  localparam logic [15:0] FWV = 16'h0213;
  localparam logic [15:0] CMD = 16'h1127;
  localparam logic [15:0] CYR = 16'h2019;
  logic         core_clk;
  logic         rst;
  logic         wr_stb;
  logic         rd_stb;
  logic [6:0]   addr;
  logic [7:0]   wdata;
  logic [15:0]  rdata;
  logic         rvalid;
  logic [15:0]  misc_control_in;
  logic [191:0] bias_correction_words;
  logic         sync_pin;
  logic         sync_oe_n;
  logic [15:0]  gyro_avg;
  logic [15:0]  accel_avg;
  logic [31:0]  delta_angle;
  logic [31:0]  delta_velocity;
  logic         sample_ready_strobe;
  logic         flt;
  logic         stimulus_on;
  logic         control_restore_stb;
  logic         cmd_busy;
  logic [7:0]   diagnostic_flags;
  int           n_errors;
  int           total_checks;
  int           sync_half;
  int           sc;
  int           n_stim;
  int           n_rest;
  imurc_regs #(.FW_VERSION(FWV), .CFG_MONTHDAY(CMD), .CFG_YEAR(CYR), .DEC_LAT_CYC(4),
    .INT_DIV(20)) dut_u (
    .core_clk, .rst, .wr_stb, .rd_stb, .addr, .wdata, .rdata, .rvalid, .misc_control_in,
    .filter_control_in(16'h0000), .misc_control_restore(), .filter_control_restore(),
    .control_restore_stb, .bias_correction_words, .sync_pin, .sync_out(), .sync_oe_n,
    .gyro_sample(16'h0123), .accel_sample(16'hfff0), .gyro_avg, .accel_avg, .delta_angle,
    .delta_velocity, .sample_ready_strobe, .flash_crc_bad(flt), .flash_save_fail(flt),
    .stest_fail(flt), .stimulus_on, .cmd_busy, .diagnostic_flags);
  imurc_host host_u (.core_clk, .wr_stb, .rd_stb, .addr, .wdata, .rdata, .rvalid,
    .sample_ready_strobe);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    n_stim <= n_stim + int'(stimulus_on === 1'b1);
    n_rest <= n_rest + int'(control_restore_stb === 1'b1);
    if (sync_half != 0) begin
      sc = sc + 1;
      if (sc >= sync_half) begin
        sc = 0;
        sync_pin <= ~sync_pin;
      end
    end
  end
  task automatic final_report();
    if (n_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input logic [6:0] a, input logic [15:0] e, input logic [15:0] m);
    logic [15:0] v;
    logic ok;
    host_u.rd16(a, v, ok);
    chk("rvalid", 1, {31'b0, ok});
    chk("rdata", {16'h0, e}, {16'h0, v & m});
  endtask
  // second gap is used: the first may straddle a restart
  task automatic gap(output int g);
    logic ok;
    host_u.wait_dr(20000, ok);
    g = 0;
    do begin
      @(posedge core_clk);
      #1;
      g++;
    end while (sample_ready_strobe !== 1'b1 && g < 20000);
  endtask
  initial begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    final_report();
  end
  initial begin
    logic [15:0] ro [3] = '{FWV, CMD, CYR};
    logic [1:0] md [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
    int hf [4] = '{50, 200, 0, 0};
    int ex [4] = '{200, 200, 40, 40};
    logic oe [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    logic [7:0] cb [6] = '{8'h10, 8'h08, 8'h08, 8'h04, 8'h02, 8'h80};
    logic fl [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    logic [7:0] ed;
    logic [15:0] v;
    logic ok;
    int g;
    int s0;
    int r0;
    rst = 1'b1;
    misc_control_in = 16'h0000;
    flt = 1'b0;
    sync_pin = 1'b0;
    sync_half = 0;
    sc = 0;
    n_stim = 0;
    n_rest = 0;
    n_errors = 0;
    total_checks = 0;
    ed = 8'h00;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rdc(7'h62, 16'h07d0, 16'hffff);
    rdc(7'h64, 16'h0000, 16'hffff);
    rdc(7'h40, 16'h0000, 16'hffff);
    for (int i = 0; i < 3; i++) begin
      host_u.wr16(7'h6c + 7'(2 * i), 16'h9999);
      rdc(7'h6c + 7'(2 * i), ro[i], 16'hffff);
    end
    host_u.wr16(7'h64, 16'hf813);
    repeat (6) @(posedge core_clk);
    rdc(7'h64, 16'h0013, 16'h07ff);
    gap(g);
    gap(g);
    chk("period", 400, g);
    chk("gyro_avg", 32'h0123, {16'h0, gyro_avg});
    chk("accel_avg", 32'hfff0, {16'h0, accel_avg});
    chk("delta_angle", 32'h000016bc, delta_angle);
    chk("delta_velocity", 32'hfffffec0, delta_velocity);
    host_u.wr16(7'h64, 16'h0001);
    host_u.wr16(7'h62, 16'h0004);
    for (int i = 0; i < 4; i++) begin
      sync_half = hf[i];
      misc_control_in <= {12'h000, md[i], 2'b00};
      gap(g);
      gap(g);
      gap(g);
      chk("mode_gap", ex[i], g);
      chk("sync_oe_n", {31'b0, oe[i]}, {31'b0, sync_oe_n});
    end
    rdc(7'h62, 16'h0004, 16'hffff);
    host_u.wr16(7'h68, 16'hff61);
    repeat (3) @(posedge core_clk);
    chk("busy_nop", 0, {31'b0, cmd_busy});
    host_u.wr16(7'h64, 16'h07cf);
    repeat (6) @(posedge core_clk);
    rdc(7'h64, 16'h07cf, 16'hffff);
    for (int i = 0; i < 6; i++) begin
      flt <= fl[i];
      s0 = n_stim;
      r0 = n_rest;
      host_u.wr_byte(7'h68, cb[i]);
      #1;
      chk("busy", 1, {31'b0, cmd_busy});
      host_u.rd16(7'h6c, v, ok);
      chk("rd_in_cmd", 0, {31'b0, ok});
      host_u.wr_byte(7'h69, 8'h00);
      for (g = 0; g < 3000 && cmd_busy !== 1'b0; g++) begin
        @(posedge core_clk);
        #1;
      end
      chk("busy_end", 0, {31'b0, cmd_busy});
      repeat (2) @(posedge core_clk);
      #1;
      if (cb[i] == 8'h10) ed[6] = ed[6] | fl[i];
      if (cb[i] == 8'h08) ed[2] = fl[i];
      if (cb[i] == 8'h04) ed[5] = fl[i];
      if (cb[i] == 8'h80) ed = 8'h00;
      if (cb[i] == 8'h80) chk("cleared", 0, delta_angle | delta_velocity | {16'h0, gyro_avg});
      chk("diag", {24'h0, ed}, {24'h0, diagnostic_flags & 8'h64});
      chk("stim", {31'b0, cb[i] == 8'h04}, {31'b0, n_stim != s0});
      chk("restore", {31'b0, cb[i] == 8'h02}, {31'b0, n_rest != r0});
      if (cb[i] == 8'h02) rdc(7'h64, 16'h0000, 16'hffff);
    end
    chk("bias", 0, {31'b0, |bias_correction_words});
    repeat (20) @(posedge core_clk);
    chk("self_clear", 0, {31'b0, cmd_busy});
    rdc(7'h62, 16'h07d0, 16'hffff);
    host_u.wait_dr(200, ok);
    chk("restart", 1, {31'b0, ok});
    final_report();
  end
endmodule // imurc_regs_tb
